// >>> core/tlp_consts.svh
`ifndef TLP_CONSTS_SVH
`define TLP_CONSTS_SVH

// ******************************
// Register offsets
// ******************************
`define TLP_OFF_PRGCTL   12'h004
`define TLP_OFF_SEQEV0   12'h100
`define TLP_OFF_SEQEV2   12'h108
`define TLP_OFF_SEQST    12'h11C
`define TLP_OFF_CNT0     12'h160
`define TLP_OFF_CNT1     12'h164
`define TLP_OFF_RSEL_LO  12'h208
`define TLP_OFF_RSEL_HI  12'h23C
`define TLP_OFF_OSLAR    12'h300
`define TLP_OFF_OSLSR    12'h304
`define TLP_OFF_PDCR     12'h310
`define TLP_OFF_PDSR     12'h314
`define TLP_OFF_SWLAR    12'hFB0
`define TLP_OFF_SWLSR    12'hFB4
`define TLP_OFF_PID4     12'hFD0
`define TLP_OFF_PID5     12'hFD4
`define TLP_OFF_PID6     12'hFD8
`define TLP_OFF_PID7     12'hFDC
`define TLP_OFF_PID0     12'hFE0
`define TLP_OFF_PID1     12'hFE4
`define TLP_OFF_PID2     12'hFE8
`define TLP_OFF_PID3     12'hFEC

// ******************************
// Field positions
// ******************************
`define TLP_OSLAR_KEY    0
`define TLP_OSLSR_LOCK   1
`define TLP_PDCR_PU      3
`define TLP_PDSR_LOCK    5
`define TLP_PDSR_STICKY  1
`define TLP_PDSR_POWER   0
`define TLP_PRG_EN       0
`define TLP_RS_PINV      21
`define TLP_RS_INV       20
`define TLP_RS_GRP       18:16
`define TLP_RS_SEL       7:0
`define TLP_SEQEV_MASK   16'h8F8F
`define TLP_SEQ_LAST     2'h3
`define TLP_OSLSR_LM1    3
`define TLP_OSLSR_LM0    0
`define TLP_OSLSR_NARROW 2
`define TLP_PID2_JEDEC   3
`define TLP_RS_RSVD      32'hFFC8_FF00

// ******************************
// Fixed values and reset values
// ******************************
`define TLP_LOCK_MODEL   2'h2
`define TLP_JEDEC_USED   1'h1
`define TLP_ID_SIZE      4'h0
`define TLP_PRG_RST      1'h0
`define TLP_PU_RST       1'h0
`define TLP_LOCK_RST     1'h0
`define TLP_STICKY_RST   1'h1

`endif

// >>> core/tlp_pkg.sv
package tlp_pkg;

  // Answer phase of the debug port
  typedef enum logic {bus_idle, bus_resp} tlp_bus_t;

  // Whole state of the register bank
  typedef struct packed {
    logic                  pwr_s1;     // Power pin, first stage
    logic                  pwr_s2;     // Power pin, second stage
    logic                  pwr_prev;   // Delayed copy for fall detect
    logic [63:0]           res_s1;     // Resource pins, first stage
    logic [63:0]           res_s2;     // Resource pins, second stage
    logic                  os_lock;    // Lock engaged
    logic                  power_keep; // Keep-powered request
    logic                  prog_en;    // Trace program enable
    logic                  sticky;     // Power lost since last read
    logic [1:0][15:0]      cnt;        // Counter values
    logic [15:2][12:0]     rsel;       // {pinv, inv, grp, sel}
    logic [2:0][15:0]      seqev;      // Sequencer transition events
    logic [1:0]            seq_state;  // Current sequencer state
    tlp_bus_t              bus;        // Answer phase
    logic [31:0]           rdata;      // Registered read data
    logic                  slverr;     // Registered error answer
  } tlp_state_t;

endpackage

// >>> core/tlp_regs.sv
`timescale 1ns/100ps
`include "tlp_consts.svh"
// What this block does
// (RULE1) Lock access bit 0 engages/releases lock
// (RULE2) Lock status bit 1 shows lock
// (RULE3) Lock model field reads binary 10
// (RULE4) Narrow transfer bit reads zero; full writes
// (RULE5) Power-down control bit 3 requests power
// (RULE6) Power request clears on unit reset
// (RULE7) Power status bit 5 mirrors lock
// (RULE8) Sticky loss bit sets on power removal
// (RULE9) Reading power status clears sticky bit
// (RULE10) Unpowered unit answers accesses with error
// (RULE11) System handles accesses to unpowered unit
// (RULE12) Program enable resets to zero, idle
// (RULE13) Enabled: trace on, config writes ignored
// (RULE14) Eight selector pairs, first pair fixed
// (RULE15) Bit 21 inverts pair result, lower
// (RULE16) Bit 20 inverts selected resource result
// (RULE17) Group in 18:16, members in 7:0
// (RULE18) Four-state sequencer, forward and back
// (RULE19) Ident 4 reports log2 page size
// (RULE20) Ident 2 bit 3 reads one
// (RULE21) Part number split across ident 0/1
// (RULE22) Ident 5 to 7 read zero
// (RULE23) Counter values in 15:0, rest zero
// (RULE24) Software lock registers read zero
// (RULE25) Reserved bits read zero, ignore writes
// (RULE26) Clearing read returns pre-clear sticky value
module tlp_regs #(
  parameter logic [11:0] PART_NUM   = 12'h9A5, // Arbitrary value
  parameter logic [6:0]  DESIGNER   = 7'h2C,   // Arbitrary value
  parameter logic [3:0]  CONT_CODE  = 4'h7,    // Arbitrary value
  parameter logic [3:0]  REVISION   = 4'h1,    // Arbitrary value
  parameter logic [3:0]  MINOR_REV  = 4'h5,    // Arbitrary value
  parameter logic [3:0]  CUST_CHG   = 4'h3     // Arbitrary value
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Debug port, slave side
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins from other domains
  input  wire logic        trace_powered,
  input  wire logic [63:0] resource_in,
  // Block controls
  output logic             power_keep_request,
  output logic             trace_enable,
  output logic             os_lock_flag,
  output logic      [1:0]  seq_state
);

  // ******************************
  // State and helpers
  // ******************************
  tlp_pkg::tlp_state_t s_r;        // Registered state
  tlp_pkg::tlp_state_t s_nxt;      // Next state
  logic                acc;        // Access phase taken now
  logic                err;        // Access refused with error
  logic                rd_pdsr;    // Clearing read of power status
  logic                pd_fall;    // Power just removed
  logic [31:0]         rd;         // Read word for this access
  logic [15:0]         sres;       // Single selector results
  logic [7:0]          pres;       // Pair results
  logic                fwd_ev;     // Sequencer forward event
  logic                back_ev;    // Sequencer backward event

  // Lock model value; its two bits sit apart in the status word
  localparam logic [1:0] LOCK_MODEL = `TLP_LOCK_MODEL;

  // Selector register range
  function automatic logic is_rsel(input logic [11:0] a);
    is_rsel = (a >= `TLP_OFF_RSEL_LO) && (a <= `TLP_OFF_RSEL_HI);
  endfunction

  // Sequencer event register range
  function automatic logic is_seqev(input logic [11:0] a);
    is_seqev = (a >= `TLP_OFF_SEQEV0) && (a <= `TLP_OFF_SEQEV2);
  endfunction

  // Configuration that freezes while tracing is enabled
  function automatic logic is_cfg(input logic [11:0] a);
    is_cfg = is_rsel(a) || is_seqev(a) || (a == `TLP_OFF_CNT0) || (a == `TLP_OFF_CNT1);
  endfunction

  // Trace registers proper; lock, power and ident stay reachable
  function automatic logic is_trace(input logic [11:0] a);
    is_trace = is_cfg(a) || (a == `TLP_OFF_PRGCTL) || (a == `TLP_OFF_SEQST);
  endfunction

  // A pair index uses only the low three select bits
  // Event from a single selector or a pair
  function automatic logic ev_pick(input logic typ, input logic [3:0] sel,
                                   input logic [15:0] sr, input logic [7:0] pr);
    ev_pick = typ ? pr[sel[2:0]] : sr[sel];
  endfunction

  // ******************************
  // Resource selectors
  // ******************************
  // (RULE14) First pair fixed
  assign sres[0] = 1'h0;
  assign sres[1] = 1'h1;

  // One evaluator per programmable selector
  genvar g;
  generate
    for (g = 2; g < 16; g++) begin : g_sel
      logic [7:0] grp_bits; // Members of the chosen group
      // (RULE17) Group and member select
      assign grp_bits = s_r.res_s2[{s_r.rsel[g][10:8], 3'h0} +: 8];
      // (RULE16) Optional result invert
      assign sres[g] = (|(grp_bits & s_r.rsel[g][7:0])) ^ s_r.rsel[g][11];
    end
    for (g = 0; g < 8; g++) begin : g_pair
      if (g == 0) begin : g_fixed
        // (RULE14) Fixed pair reads true
        assign pres[g] = sres[2*g] | sres[2*g+1];
      end else begin : g_prog
        // (RULE15) Pair invert held in lower register
        assign pres[g] = (sres[2*g] | sres[2*g+1]) ^ s_r.rsel[2*g][12];
      end
    end
  endgenerate

  // ******************************
  // Sequencer events
  // ******************************
  // Forward wins a tie, so the state takes one step per cycle
  // (RULE18) Forward uses this state, back the one below
  always_comb begin
    fwd_ev  = 1'h0;
    back_ev = 1'h0;
    if (s_r.seq_state != `TLP_SEQ_LAST) begin
      fwd_ev = ev_pick(s_r.seqev[s_r.seq_state][7], s_r.seqev[s_r.seq_state][3:0], sres, pres);
    end
    if (s_r.seq_state != 2'h0) begin
      back_ev = ev_pick(s_r.seqev[s_r.seq_state - 2'h1][15],
                        s_r.seqev[s_r.seq_state - 2'h1][11:8], sres, pres);
    end
  end

  // ******************************
  // Read mux
  // ******************************
  // Word seen by a read at the current address
  always_comb begin
    rd = 32'h0000_0000;
    if (is_rsel(paddr)) begin
      // (RULE25) Reserved bits of selectors read zero
      rd[`TLP_RS_PINV] = s_r.rsel[paddr[5:2]][12];
      rd[`TLP_RS_INV]  = s_r.rsel[paddr[5:2]][11];
      rd[`TLP_RS_GRP]  = s_r.rsel[paddr[5:2]][10:8];
      rd[`TLP_RS_SEL]  = s_r.rsel[paddr[5:2]][7:0];
    end else if (is_seqev(paddr)) begin
      rd[15:0] = s_r.seqev[paddr[3:2]];
    end else begin
      case (paddr)
        `TLP_OFF_PRGCTL: rd[`TLP_PRG_EN] = s_r.prog_en;
        `TLP_OFF_SEQST:  rd[1:0] = s_r.seq_state;
        // (RULE23) Counter value in the low half
        `TLP_OFF_CNT0:   rd[15:0] = s_r.cnt[0];
        `TLP_OFF_CNT1:   rd[15:0] = s_r.cnt[1];
        `TLP_OFF_OSLSR: begin
          // (RULE3) Lock model split over bits 3 and 0
          rd[`TLP_OSLSR_LM1] = LOCK_MODEL[1];
          rd[`TLP_OSLSR_LM0] = LOCK_MODEL[0];
          // (RULE2) Lock state
          rd[`TLP_OSLSR_LOCK] = s_r.os_lock;
          // (RULE4) Narrow transfer bit left zero
          rd[`TLP_OSLSR_NARROW] = 1'h0;
        end
        `TLP_OFF_PDCR:   rd[`TLP_PDCR_PU] = s_r.power_keep;
        `TLP_OFF_PDSR: begin
          // (RULE7) Lock mirror
          rd[`TLP_PDSR_LOCK]   = s_r.os_lock;
          // (RULE26) Value from before the clear
          rd[`TLP_PDSR_STICKY] = s_r.sticky;
          rd[`TLP_PDSR_POWER]  = s_r.pwr_s2;
        end
        // (RULE19) One page, so log2 size is zero
        `TLP_OFF_PID4:   rd[7:0] = {`TLP_ID_SIZE, CONT_CODE};
        // (RULE21) Part number low byte, then high nibble
        `TLP_OFF_PID0:   rd[7:0] = PART_NUM[7:0];
        `TLP_OFF_PID1:   rd[7:0] = {DESIGNER[3:0], PART_NUM[11:8]};
        // (RULE20) Identity scheme flag
        `TLP_OFF_PID2:   rd[7:0] = {REVISION, `TLP_JEDEC_USED, DESIGNER[6:4]};
        `TLP_OFF_PID3:   rd[7:0] = {MINOR_REV, CUST_CHG};
        // (RULE22) Ident 5 to 7 stay zero
        // (RULE24) Software lock registers stay zero
        default:         rd = 32'h0000_0000;
      endcase
    end
  end

  // ******************************
  // Next state
  // ******************************
  // The answer cycle still shows psel and penable; the idle test
  // keeps one transfer from being taken twice
  assign acc     = psel && penable && (s_r.bus == tlp_pkg::bus_idle);
  // (RULE10) Unpowered unit refuses trace registers; (RULE1) so does the lock
  assign err     = is_trace(paddr) && (!s_r.pwr_s2 || s_r.os_lock);
  assign rd_pdsr = acc && !pwrite && (paddr == `TLP_OFF_PDSR);
  assign pd_fall = s_r.pwr_prev && !s_r.pwr_s2;

  // All state updates in one place
  always_comb begin
    s_nxt = s_r;
    // Two-stage synchronisers; first stage feeds only the second
    s_nxt.pwr_s1   = trace_powered;
    s_nxt.pwr_s2   = s_r.pwr_s1;
    s_nxt.pwr_prev = s_r.pwr_s2;
    s_nxt.res_s1   = resource_in;
    s_nxt.res_s2   = s_r.res_s1;
    // A loss in the cycle of a clearing read must not be missed
    // (RULE8) Set on removal; (RULE9) cleared by read, set wins
    s_nxt.sticky = pd_fall || (s_r.sticky && !rd_pdsr);
    // (RULE18) Sequencer steps only while tracing; forward first
    if (s_r.prog_en && fwd_ev) begin
      s_nxt.seq_state = s_r.seq_state + 2'h1;
    end else if (s_r.prog_en && back_ev) begin
      s_nxt.seq_state = s_r.seq_state - 2'h1;
    end
    // Answer phase lasts one cycle
    if (s_r.bus == tlp_pkg::bus_resp) begin
      s_nxt.bus    = tlp_pkg::bus_idle;
      s_nxt.slverr = 1'h0;
    end else if (acc) begin
      s_nxt.bus    = tlp_pkg::bus_resp;
      s_nxt.slverr = err;
      s_nxt.rdata  = (pwrite || err) ? 32'h0000_0000 : rd;
      if (pwrite && !err) begin
        case (paddr)
          // (RULE1) Key bit engages or releases
          `TLP_OFF_OSLAR:  s_nxt.os_lock = pwdata[`TLP_OSLAR_KEY];
          // (RULE5) Keep-powered request
          `TLP_OFF_PDCR:   s_nxt.power_keep = pwdata[`TLP_PDCR_PU];
          `TLP_OFF_PRGCTL: s_nxt.prog_en = pwdata[`TLP_PRG_EN];
          default:         s_nxt.os_lock = s_r.os_lock;
        endcase
        // (RULE13) Configuration frozen while enabled
        if (is_cfg(paddr) && !s_r.prog_en) begin
          if (is_rsel(paddr)) begin
            // (RULE15) Pair invert only kept in even registers
            s_nxt.rsel[paddr[5:2]] = {pwdata[`TLP_RS_PINV] & ~paddr[2], pwdata[`TLP_RS_INV],
                                      pwdata[`TLP_RS_GRP], pwdata[`TLP_RS_SEL]};
          end else if (is_seqev(paddr)) begin
            // (RULE25) Reserved bits dropped
            s_nxt.seqev[paddr[3:2]] = pwdata[15:0] & `TLP_SEQEV_MASK;
          end else begin
            // (RULE23) Only the low half is kept
            s_nxt.cnt[paddr[2]] = pwdata[15:0];
          end
        end
      end
    end
  end

  // ******************************
  // State register
  // ******************************
  // Sticky resets to one: nothing programmed survives a reset
  // (RULE6) (RULE12) Reset clears power request and enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r            <= '0;
      s_r.os_lock    <= `TLP_LOCK_RST;
      s_r.power_keep <= `TLP_PU_RST;
      s_r.prog_en    <= `TLP_PRG_RST;
      s_r.sticky     <= `TLP_STICKY_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  // Answer straight from flops, so it cannot glitch
  assign pready             = (s_r.bus == tlp_pkg::bus_resp);
  assign prdata             = s_r.rdata;
  assign pslverr            = s_r.slverr;
  // (RULE5) Request straight from the register bit
  assign power_keep_request = s_r.power_keep;
  // (RULE12) Interface idle while enable is low
  assign trace_enable       = s_r.prog_en;
  assign os_lock_flag       = s_r.os_lock;
  assign seq_state          = s_r.seq_state;

  // ******************************
  // Assertions
  // ******************************
  // Most checks look one cycle after the taken edge, where the answer stands
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  lock_write_a: assert property (acc && pwrite && !err && paddr == `TLP_OFF_OSLAR // (RULE1)
    |=> os_lock_flag == $past(pwdata[0]) ##1 os_lock_flag == $past(pwdata[0], 2))
    else $error("lock does not follow key write");

  lock_status_a: assert property (acc && !pwrite && paddr == `TLP_OFF_OSLSR // (RULE2)
    |=> pready && prdata == {28'h000_0000, 1'h1, 1'h0, $past(os_lock_flag), 1'h0})
    else $error("lock status word wrong");

  power_req_a: assert property (acc && pwrite && !err && paddr == `TLP_OFF_PDCR // (RULE5)
    |=> power_keep_request == $past(pwdata[3]))
    else $error("power request does not follow write");

  pd_mirror_a: assert property (acc && !pwrite && paddr == `TLP_OFF_PDSR // (RULE7)
    |=> prdata[5] == $past(os_lock_flag) && prdata[31:6] == 26'h000_0000)
    else $error("power status lock mirror wrong");

  sticky_set_a: assert property ($fell(s_r.pwr_s2) |=> s_r.sticky) // (RULE8)
    else $error("sticky flag not set on power loss");

  sticky_clear_a: assert property (rd_pdsr && !pd_fall // (RULE9)
    |=> !s_r.sticky && prdata[1] == $past(s_r.sticky))
    else $error("sticky clear or returned value wrong");

  power_error_a: assert property (acc && is_trace(paddr) && !s_r.pwr_s2 // (RULE10)
    |=> pready && pslverr ##1 !pready && !pslverr)
    else $error("unpowered access not refused");

  cfg_frozen_a: assert property (acc && pwrite && trace_enable && is_cfg(paddr) // (RULE13)
    |=> $stable(s_r.rsel) && $stable(s_r.seqev) && $stable(s_r.cnt))
    else $error("config changed while enabled");

  seq_hold_a: assert property (!trace_enable |=> $stable(seq_state)) // (RULE18)
    else $error("sequencer moved while disabled");

  ident_zero_a: assert property (acc && !pwrite && paddr == `TLP_OFF_PID5 // (RULE22)
    |=> prdata == 32'h0000_0000 && !pslverr)
    else $error("reserved ident not zero");

  reset_clear_a: assert property ($rose(rstn) // (RULE6) (RULE12)
    |-> !power_keep_request && !trace_enable && !pready)
    else $error("outputs not clear after reset");

  prog_write_a: assert property (acc && pwrite && !err && paddr == `TLP_OFF_PRGCTL // (RULE13)
    |=> trace_enable == $past(pwdata[`TLP_PRG_EN]))
    else $error("enable does not follow write");

  narrow_zero_a: assert property (acc && !pwrite && paddr == `TLP_OFF_OSLSR // (RULE4)
    |=> !prdata[`TLP_OSLSR_NARROW] && prdata[31:4] == 28'h000_0000)
    else $error("lock status reserved bits set");

  rsel_zero_a: assert property (acc && !pwrite && !err && is_rsel(paddr) // (RULE25)
    |=> (prdata & `TLP_RS_RSVD) == 32'h0000_0000)
    else $error("selector reserved bits set");

  cnt_high_a: assert property (acc && !pwrite && !err // (RULE23)
    && (paddr == `TLP_OFF_CNT0 || paddr == `TLP_OFF_CNT1) |=> prdata[31:16] == 16'h0000)
    else $error("counter upper half not zero");

  ident_flag_a: assert property (acc && !pwrite && paddr == `TLP_OFF_PID2 // (RULE20)
    |=> prdata[`TLP_PID2_JEDEC] && prdata[31:8] == 24'h00_0000)
    else $error("identity scheme flag wrong");

  sw_lock_zero_a: assert property (acc && !pwrite // (RULE24)
    && (paddr == `TLP_OFF_SWLAR || paddr == `TLP_OFF_SWLSR) |=> prdata == 32'h0000_0000 && !pslverr)
    else $error("software lock register not zero");

  // Main scenarios
  lock_cov: cover property (acc && pwrite && paddr == `TLP_OFF_OSLAR && pwdata[0]);
  sticky_cov: cover property (s_r.sticky && rd_pdsr);
  seq_cov: cover property (trace_enable && fwd_ev ##1 back_ev);
  err_cov: cover property (pready && pslverr);

endmodule

// >>> tb/tlp_dbg_model.sv
`timescale 1ns/100ps
// ************************************
// Debugger model on the debug port
// ************************************
module tlp_dbg_model (
  // Clock
  input  wire logic        core_clk,
  // Bus toward the register bank
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // One transfer: setup, access, wait for ready; x comes back on a hang
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n   = 0;
    rd  = 'x;
    err = 1'bx;
    @(negedge core_clk);
    psel   = 1'b1;
    pwrite = we;
    paddr  = a;
    pwdata = wd;
    @(negedge core_clk);
    penable = 1'b1;
    // Hold everything until ready is seen at a rising edge
    while (n < 8) begin
      @(posedge core_clk);
      n++;
      if (pready === 1'b1) begin
        rd  = prdata;
        err = pslverr;
        n   = 99;
      end
    end
    @(negedge core_clk);
    psel    = 1'b0;
    penable = 1'b0;
    // Released lines carry junk, so stale values cannot pass
    paddr  = ~a;
    pwdata = ~wd;
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
// Compare and count; an unknown matches only an unknown
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t: got %0h exp %0h", $time, g, e); end end
// ******************************
// Register bank bench
// ******************************
module tb;
  // Ident values, arbitrary
  localparam logic [11:0] PART = 12'h3C7;
  localparam logic [6:0]  DES  = 7'h15;
  localparam logic [3:0]  CONT = 4'h4;
  localparam logic [3:0]  REV  = 4'h6;
  localparam logic [3:0]  MINR = 4'h9;
  localparam logic [3:0]  CUST = 4'hB;
  localparam int          NR   = 33;

  // Table row: write flag, address, data, expected data, expected error
  typedef struct packed {logic we; logic [11:0] a; logic [31:0] wd; logic [31:0] ex; logic er;} tlp_row_t;

  logic        core_clk, rstn, trace_powered;      // Clock, reset, power pin
  logic [63:0] resource_in;                        // Resource pins
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;                              // Bus address
  logic [31:0] pwdata, prdata;                     // Bus data
  logic        power_keep_request, trace_enable, os_lock_flag;
  logic [1:0]  seq_state;                          // Sequencer state
  int          fail_count, num_checks, cyc;       // Counters

  // Ordinary cases, run in order
  tlp_row_t rows [NR] = '{
    '{1'b0, 12'h304, 32'h0, 32'h8, 1'b0},
    '{1'b0, 12'h314, 32'h0, 32'h3, 1'b0},
    '{1'b0, 12'h314, 32'h0, 32'h1, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h310, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b0, 12'h310, 32'h0, 32'h8, 1'b0},
    '{1'b1, 12'h160, 32'hFFFF_1234, 32'h0, 1'b0},
    '{1'b0, 12'h160, 32'h0, 32'h1234, 1'b0},
    '{1'b1, 12'h208, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b0, 12'h208, 32'h0, 32'h37_00FF, 1'b0},
    '{1'b1, 12'h23C, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b0, 12'h23C, 32'h0, 32'h17_00FF, 1'b0},
    '{1'b0, 12'h200, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'hFB0, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b0, 12'hFB0, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'hFB4, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h500, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b0, 12'h500, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h100, 32'hFFFF_FFFF, 32'h0, 1'b0},
    '{1'b0, 12'h100, 32'h0, 32'h8F8F, 1'b0},
    '{1'b0, 12'hFE0, 32'h0, {24'h0, PART[7:0]}, 1'b0},
    '{1'b0, 12'hFE4, 32'h0, {24'h0, DES[3:0], PART[11:8]}, 1'b0},
    '{1'b0, 12'hFE8, 32'h0, {24'h0, REV, 1'b1, DES[6:4]}, 1'b0},
    '{1'b0, 12'hFEC, 32'h0, {24'h0, MINR, CUST}, 1'b0},
    '{1'b0, 12'hFD0, 32'h0, {24'h0, 4'h0, CONT}, 1'b0},
    '{1'b0, 12'hFD4, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'hFD8, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'hFDC, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h100, 32'h0080, 32'h0, 1'b0},       // Forward on fixed pair
    '{1'b1, 12'h104, 32'h0102, 32'h0, 1'b0},       // Forward on selector 2, back on 1
    '{1'b1, 12'h108, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h208, 32'h11_0002, 32'h0, 1'b0},    // Group 1 member 1 inverted
    '{1'b0, 12'h208, 32'h0, 32'h11_0002, 1'b0}};

  // Unit under test
  tlp_regs #(.PART_NUM(PART), .DESIGNER(DES), .CONT_CODE(CONT), .REVISION(REV),
             .MINOR_REV(MINR), .CUST_CHG(CUST)) uut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trace_powered(trace_powered), .resource_in(resource_in),
    .power_keep_request(power_keep_request), .trace_enable(trace_enable),
    .os_lock_flag(os_lock_flag), .seq_state(seq_state));

  // Debugger on the far side
  tlp_dbg_model dbg (
    .core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Clock, 10 ns period
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One transfer with its expected answer
  task automatic go(input logic we, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] ex,
                    input logic er);
    logic [31:0] rd;
    logic        e;
    dbg.xfer(we, a, wd, rd, e);
    `CHK(rd, ex)
    `CHK(e, er)
  endtask

  // Hang guard; a run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    rstn          = 1'b0;
    trace_powered = 1'b1;
    resource_in   = 64'h0000_0000_0000_0200;
    repeat (8) @(negedge core_clk);
    `CHK(power_keep_request, 1'b0)
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < NR; i++) begin
      go(rows[i].we, rows[i].a, rows[i].wd, rows[i].ex, rows[i].er);
    end
    $display("test table done");
    // Enable: fixed pair steps to state 1, config writes dropped
    go(1'b1, 12'h004, 32'hFFFF_FFFF, 32'h0, 1'b0);
    `CHK(trace_enable, 1'b1)
    go(1'b1, 12'h160, 32'h7777, 32'h0, 1'b0);
    go(1'b0, 12'h160, 32'h0, 32'h1234, 1'b0);
    go(1'b0, 12'h004, 32'h0, 32'h1, 1'b0);
    go(1'b0, 12'h11C, 32'h0, 32'h1, 1'b0);
    // Inverted resource turns true once its pin drops
    resource_in = 64'h0;
    for (int k = 0; k < 12 && seq_state !== 2'h2; k++) @(negedge core_clk);
    `CHK(seq_state, 2'h2)
    // Pin restored: forward goes false, the back step settles in state 1
    resource_in = 64'h0000_0000_0000_0200;
    repeat (4) @(negedge core_clk);
    `CHK(seq_state, 2'h1)
    go(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
    `CHK(trace_enable, 1'b0)
    $display("test sequencer done");
    // Lock shuts trace registers out
    go(1'b1, 12'h300, 32'h1, 32'h0, 1'b0);
    `CHK(os_lock_flag, 1'b1)
    go(1'b0, 12'h304, 32'h0, 32'hA, 1'b0);
    go(1'b0, 12'h314, 32'h0, 32'h21, 1'b0);
    go(1'b0, 12'h160, 32'h0, 32'h0, 1'b1);
    go(1'b1, 12'h300, 32'h0, 32'h0, 1'b0);
    `CHK(os_lock_flag, 1'b0)
    go(1'b0, 12'h314, 32'h0, 32'h1, 1'b0);
    $display("test lock done");
    // Power loss: errors, sticky flag, then recovery
    trace_powered = 1'b0;
    repeat (6) @(negedge core_clk);
    go(1'b0, 12'h004, 32'h0, 32'h0, 1'b1);
    go(1'b0, 12'h314, 32'h0, 32'h2, 1'b0);
    trace_powered = 1'b1;
    repeat (6) @(negedge core_clk);
    go(1'b0, 12'h314, 32'h0, 32'h1, 1'b0);
    go(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
    $display("test power done");
    // Keep request, then a reset in mid-run
    go(1'b1, 12'h310, 32'h8, 32'h0, 1'b0);
    `CHK(power_keep_request, 1'b1)
    rstn = 1'b0;
    @(negedge core_clk);
    `CHK(power_keep_request, 1'b0)
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    go(1'b0, 12'h310, 32'h0, 32'h0, 1'b0);
    go(1'b0, 12'h314, 32'h0, 32'h3, 1'b0);
    $display("test reset done");
    wrap_up();
  end
endmodule
